// ### rtl/vcom_dac_i2c_slave.sv
// two-wire slave holding a 7-bit current-sink code and its eeprom copy
// assumes open-drain wires resolved outside; lclk samples the bus pins
//
// Function
// - a transfer may begin from any state, both lines high, while the ctrl enable bit is set
// - start (data falls, clock high) restarts byte reception
// - respond only to address bytes 9e and 9f, direction bit ignored in the match
// - direction high returns register, low stores a new setting
// - acknowledge by holding data low through the ninth clock high
// - data byte is seven code bits msb first, then program flag
// - read flag is 1 when programming done, 0 while busy
// - flag 1 writes register only, flag 0 also programs eeprom
// - stop (data rises, clock high) returns to waiting for start
// - bus works at clock rates up to 400 kbps
// - code selects one of 128 steps, level is code plus one
// - eeprom programming only while unlock input is high
// - at power-up the eeprom contents load the dac register
`timescale 1ns/10ps
module vcom_dac_i2c_slave
  import vcom_pkg::*;
#(
  parameter int EE_CYC = EE_PROG_CYC
) (
  // system clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // wishbone slave
  input  wire wb_req_t    wb_i,
  output logic            wb_ack_o,
  output logic [31:0]     wb_dat_o,
  // serial link
  input  wire logic       lclk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // device pins and analog control
  input  wire logic       eeprom_unlock_in,
  output logic [6:0]      dac_code,
  output logic [7:0]      dac_steps,
  output logic            ee_busy
);

  // ********************************************************************
  // link domain
  // ********************************************************************
  logic       lrs_q1, lrst_n;
  logic       scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
  logic       en_q1, en_q2, stt_q1, stt_q2, stt_q3;
  lstate_t    state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, rdw_r, rdw_nxt, wrb_r, wrb_nxt;
  logic       rw_r, rw_nxt, oe_r, oe_nxt, wrt_r, wrt_nxt, sack_r, sack_nxt;
  logic       rise, fall, start, stop, st_new;

  // mclk side signals read across
  logic [7:0] st_hold_r, st_hold_nxt;
  logic       st_tgl_r, st_tgl_nxt, ctrl_en_r, ctrl_en_nxt;

  // reset and pin synchronisers, third stage for edge detection
  always_ff @(posedge lclk) begin
    lrs_q1 <= rst_n;
    lrst_n <= lrs_q1;
    scl_q1 <= scl_in;
    scl_q2 <= scl_q1;
    scl_q3 <= scl_q2;
    sda_q1 <= sda_in;
    sda_q2 <= sda_q1;
    sda_q3 <= sda_q2;
    en_q1  <= ctrl_en_r;
    en_q2  <= en_q1;
    stt_q1 <= st_tgl_r;
    stt_q2 <= stt_q1;
    stt_q3 <= stt_q2;
  end

  // bus events; 20 samples per bit at 400 kbps keep edges apart
  assign rise   = scl_q2 & ~scl_q3;
  assign fall   = ~scl_q2 & scl_q3;
  assign start  = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
  assign stop   = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;
  assign st_new = stt_q2 ^ stt_q3;

  // slave sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    rw_nxt    = rw_r;
    oe_nxt    = oe_r;
    wrb_nxt   = wrb_r;
    wrt_nxt   = wrt_r;
    rdw_nxt   = rdw_r;
    sack_nxt  = sack_r;
    // status word is stable while its toggle is pending
    if (st_new) begin
      rdw_nxt  = st_hold_r;
      sack_nxt = ~sack_r;
    end
    if (stop || (start && !en_q2)) begin
      state_nxt = L_IDLE;
      oe_nxt    = 1'b0;
    end else if (start) begin
      state_nxt = L_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else begin
      unique case (state_r)
        L_IDLE: begin
          oe_nxt = 1'b0; // only a start on an idle bus leaves here
        end
        L_ADDR, L_WR: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], sda_q2}; // msb first
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'(BYTE_BITS)) begin
            cnt_nxt = 4'h0;
            if (state_r == L_WR) begin
              oe_nxt    = 1'b1;
              state_nxt = L_WACK;
              wrb_nxt   = sh_r;
              wrt_nxt   = ~wrt_r;
            end else if (sh_r[7:1] == SLAVE_ADDR) begin
              oe_nxt    = 1'b1;
              rw_nxt    = sh_r[0];
              state_nxt = L_AACK;
            end else begin
              state_nxt = L_IDLE;
            end
          end
        end
        L_AACK, L_WACK: begin
          // ack released on the fall closing the ninth clock
          if (fall) begin
            if (state_r == L_AACK && rw_r) begin
              state_nxt = L_RD;
              sh_nxt    = rdw_r;
              oe_nxt    = ~rdw_r[7];
            end else begin
              state_nxt = L_WR; // further bytes accepted
              oe_nxt    = 1'b0;
            end
          end
        end
        L_RD: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == 4'(BYTE_BITS)) begin
              oe_nxt    = 1'b0;
              state_nxt = L_RACK;
              cnt_nxt   = 4'h0;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        L_RACK: begin
          if (rise && sda_q2) begin
            state_nxt = L_IDLE; // master declined more data
          end else if (fall) begin
            state_nxt = L_RD;
            sh_nxt    = rdw_r;
            oe_nxt    = ~rdw_r[7];
          end
        end
      endcase
    end
  end

  // link registers
  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      state_r <= L_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      wrb_r   <= 8'h00;
      wrt_r   <= 1'b0;
      rdw_r   <= 8'h00;
      sack_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      wrb_r   <= wrb_nxt;
      wrt_r   <= wrt_nxt;
      rdw_r   <= rdw_nxt;
      sack_r  <= sack_nxt;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe  = oe_r;

  // ********************************************************************
  // system domain
  // ********************************************************************
  logic              unl_q1, unl_q2, wrt_q1, wrt_q2, wrt_q3, sak_q1, sak_q2;
  logic [6:0]        code_r, code_nxt, ee_r, ee_nxt, eev_r, eev_nxt;
  logic [7:0]        steps_r, steps_nxt;
  logic              busy_r, busy_nxt, load_r, load_nxt;
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt;
  logic              ack_r, ack_nxt;
  logic [31:0]       dat_r, dat_nxt;
  logic              wr_evt, st_pend, bus_req;
  logic [7:0]        st_word;

  // synchronisers toward mclk
  always_ff @(posedge mclk) begin
    unl_q1 <= eeprom_unlock_in;
    unl_q2 <= unl_q1;
    wrt_q1 <= wrt_r;
    wrt_q2 <= wrt_q1;
    wrt_q3 <= wrt_q2;
    sak_q1 <= sack_r;
    sak_q2 <= sak_q1;
  end

  // the received byte holds for a whole byte time after its toggle
  assign wr_evt  = wrt_q2 ^ wrt_q3;
  assign st_pend = st_tgl_r ^ sak_q2;
  assign st_word = {code_r, ~busy_r};
  assign bus_req = wb_i.cyc & wb_i.stb & ~ack_r;

  // code, eeprom, status handshake and register bus
  always_comb begin
    code_nxt    = code_r;
    ee_nxt      = ee_r;
    eev_nxt     = eev_r;
    busy_nxt    = busy_r;
    pcnt_nxt    = pcnt_r;
    load_nxt    = 1'b0;
    st_hold_nxt = st_hold_r;
    st_tgl_nxt  = st_tgl_r;
    ctrl_en_nxt = ctrl_en_r;
    steps_nxt   = {1'b0, code_r} + 8'h01;
    if (load_r) begin
      code_nxt = ee_r;
    end
    if (busy_r) begin
      pcnt_nxt = pcnt_r - PCNT_W'(1);
      if (pcnt_r == PCNT_W'(1)) begin
        ee_nxt   = eev_r;
        busy_nxt = 1'b0;
      end
    end
    if (wr_evt) begin
      code_nxt = wrb_r[7:1];
      if (!wrb_r[0] && unl_q2 && !busy_r) begin
        busy_nxt = 1'b1;
        pcnt_nxt = PCNT_W'(EE_CYC);
        eev_nxt  = wrb_r[7:1];
      end
    end
    if (!st_pend && st_word != st_hold_r) begin
      st_hold_nxt = st_word;
      st_tgl_nxt  = ~st_tgl_r;
    end
    ack_nxt = bus_req;
    dat_nxt = 32'h0000_0000; // unmapped reads return zero
    if (bus_req && wb_i.we && wb_i.adr == REG_CTRL && wb_i.sel[0]) begin
      ctrl_en_nxt = wb_i.dat[CTRL_EN_BIT];
    end
    if (bus_req && !wb_i.we) begin
      if (wb_i.adr == REG_CTRL) begin
        dat_nxt[CTRL_EN_BIT] = ctrl_en_r;
      end else if (wb_i.adr == REG_STAT) begin
        dat_nxt[6:0]                        = code_r;
        dat_nxt[STAT_BUSY_BIT]              = busy_r;
        dat_nxt[STAT_EE_LSB +: 7]           = ee_r;
        dat_nxt[STAT_UNL_BIT]               = unl_q2;
      end
    end
  end

  // system registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_r    <= 7'h00;
      ee_r      <= EE_INIT;
      eev_r     <= 7'h00;
      steps_r   <= 8'h01;
      busy_r    <= 1'b0;
      pcnt_r    <= '0;
      load_r    <= 1'b1;
      st_hold_r <= 8'h00;
      st_tgl_r  <= 1'b0;
      ctrl_en_r <= CTRL_EN_RST;
      ack_r     <= 1'b0;
      dat_r     <= 32'h0000_0000;
    end else begin
      code_r    <= code_nxt;
      ee_r      <= ee_nxt;
      eev_r     <= eev_nxt;
      steps_r   <= steps_nxt;
      busy_r    <= busy_nxt;
      pcnt_r    <= pcnt_nxt;
      load_r    <= load_nxt;
      st_hold_r <= st_hold_nxt;
      st_tgl_r  <= st_tgl_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
    end
  end

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign dac_code  = code_r;
  assign dac_steps = steps_r;
  assign ee_busy   = busy_r;

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_start;
    @(posedge lclk) disable iff (!lrst_n)
    (start && en_q2 && !stop) |=> (state_r == L_ADDR && cnt_r == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge lclk) disable iff (!lrst_n)
    stop |=> (state_r == L_IDLE && !sda_oe);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_addr;
    @(posedge lclk) disable iff (!lrst_n)
    (state_r == L_ADDR && fall && !start && !stop && cnt_r == 4'h8)
      |=> (sda_oe == ($past(sh_r[7:1]) == SLAVE_ADDR));
  endproperty
  a_addr: assert property (p_addr) else $error("address match wrong");

  property p_ack;
    @(posedge lclk) disable iff (!lrst_n)
    (state_r == L_AACK || state_r == L_WACK) |-> sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not driven");

  property p_regonly;
    @(posedge mclk) disable iff (!rst_n)
    (wr_evt && wrb_r[0] && !busy_r)
      |=> (!busy_r && code_r == $past(wrb_r[7:1]));
  endproperty
  a_regonly: assert property (p_regonly) else $error("flag 1 write");

  property p_eeprog;
    @(posedge mclk) disable iff (!rst_n)
    (wr_evt && !wrb_r[0] && unl_q2 && !busy_r)
      |=> (busy_r && eev_r == $past(wrb_r[7:1]));
  endproperty
  a_eeprog: assert property (p_eeprog) else $error("no eeprom start");

  property p_locked;
    @(posedge mclk) disable iff (!rst_n)
    (wr_evt && !unl_q2 && !busy_r) |=> (!busy_r && $stable(ee_r));
  endproperty
  a_locked: assert property (p_locked) else $error("locked write");

  property p_reload;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |=> (code_r == ee_r);
  endproperty
  a_reload: assert property (p_reload) else $error("no power-up load");

  property p_steps;
    @(posedge mclk) disable iff (!rst_n)
    $changed(code_r) |=> (dac_steps == {1'b0, $past(code_r)} + 8'h01);
  endproperty
  a_steps: assert property (p_steps) else $error("steps wrong");

endmodule

// ### rtl/vcom_pkg.sv
// constants, carrier types and state codes of the vcom dac serial slave
// assumes a 100 MHz system clock and a separate link sampling clock
package vcom_pkg;

  // ********************************************************************
  // link and bus constants
  // ********************************************************************
  localparam logic [6:0] SLAVE_ADDR    = 7'h4f; // 9e with r/w bit dropped
  localparam int         LINK_MAX_KBPS = 400;   // fast mode ceiling
  localparam int         BYTE_BITS     = 8;
  localparam int         ADR_W         = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STAT      = 8'h04;
  localparam int         CTRL_EN_BIT   = 0;
  localparam logic       CTRL_EN_RST   = 1'b1;
  localparam int         STAT_BUSY_BIT = 7;
  localparam int         STAT_EE_LSB   = 8;
  localparam int         STAT_UNL_BIT  = 15;

  // ********************************************************************
  // memory and timing
  // ********************************************************************
  localparam logic [6:0] EE_INIT     = 7'h40;  // stored code at power-on
  localparam int         CLK_NS      = 10;
  localparam int         EE_PROG_NS  = 5000;   // eeprom program time
  localparam int         EE_PROG_CYC = (EE_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int         PCNT_W      = 16;

  // ********************************************************************
  // carriers and states
  // ********************************************************************
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
    logic [3:0]       sel;
  } wb_req_t;

  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_AACK, L_WR, L_WACK, L_RD, L_RACK
  } lstate_t;

endpackage

// ### tb/i2c_master_model.sv
// two-wire bus master model: drives the clock wire and the data wire
// assumes a pull-up on the data wire; a released line reads high
`timescale 1ns/10ps
module i2c_master_model (
  // link clock and resolved data wire
  input  wire logic lclk,
  input  wire logic sda,
  // master wires, 1 = released
  output logic      scl_m,
  output logic      sda_m
);
  // ********************************************************************
  // bus primitives
  // ********************************************************************
  // clock stands still high between frames
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // start from an idle bus, or repeated start from a low clock
  task automatic start();
    tick(6);
    sda_m <= 1'b1;
    tick(6);
    scl_m <= 1'b1;
    tick(8);
    sda_m <= 1'b0;
    tick(8);
    scl_m <= 1'b0;
  endtask
  // data rises while clock high
  task automatic stop();
    tick(6);
    sda_m <= 1'b0;
    tick(6);
    scl_m <= 1'b1;
    tick(8);
    sda_m <= 1'b1;
    tick(8);
  endtask
  // one bit of 20 lclk, 2.5 us, so 400 kbps
  task automatic bitx(input logic b, output logic r);
    tick(6);
    sda_m <= b;
    tick(6);
    scl_m <= 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl_m <= 1'b0;
  endtask
  // byte msb first, then a ninth clock for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // read byte, then ack or nack it
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(nack, r);
  endtask
endmodule

// ### tb/testbench.sv
// self-checking bench: wishbone tasks plus a two-wire master model
// assumes the slave sinks the data wire only, pull-up otherwise
`timescale 1ns/10ps
module testbench;
  import vcom_pkg::*;
  logic        mclk, rst_n, lclk, unl, a1, a2, b;
  wb_req_t     wb_i;
  logic        wb_ack_o, sda_out, sda_oe, ee_busy, scl_m, sda_m;
  logic [31:0] wb_dat_o, rd;
  logic [6:0]  dac_code;
  logic [7:0]  dac_steps, d;
  wire         sda = sda_m & ~(sda_oe & ~sda_out);
  int          miscompares, checks;
  // ********************************************************************
  // clocks, design and partner
  // ********************************************************************
  always #5 mclk = ~mclk;
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #62.5 lclk = ~lclk;
  end
  vcom_dac_i2c_slave #(.EE_CYC(20000)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .lclk(lclk), .scl_in(scl_m), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .eeprom_unlock_in(unl),
    .dac_code(dac_code), .dac_steps(dac_steps), .ee_busy(ee_busy));
  i2c_master_model m_u (.lclk(lclk), .sda(sda), .scl_m(scl_m),
    .sda_m(sda_m));
  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h0, g}, {7'h0, e});
  endtask
  // single classic cycle, held until ack is sampled high; a hang is
  // left to the watchdog
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] wd, output logic [31:0] r);
    @(posedge mclk);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, dat: wd, sel: 4'hf};
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_i <= '0;
  endtask
  task automatic i2w(input logic [7:0] a, input logic [7:0] v,
                     output logic k1, output logic k2);
    m_u.start();
    m_u.wbyte(a, k1);
    m_u.wbyte(v, k2);
    m_u.stop();
  endtask
  task automatic i2r(output logic k1, output logic [7:0] v);
    m_u.start();
    m_u.wbyte(8'h9f, k1);
    m_u.rbyte(1'b1, v);
    m_u.stop();
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (98000) @(posedge mclk);
    miscompares++;
    results();
  end
  // ********************************************************************
  // tests
  // ********************************************************************
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    unl = 1'b0;
    wb_i = '0;
    miscompares = 0;
    checks = 0;
    repeat (12) @(posedge lclk);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge lclk);
    wb(1'b0, REG_STAT, 32'h0, rd);
    cmp8({1'b0, rd[6:0]}, 8'h40);
    cmp8({1'b0, rd[14:8]}, 8'h40);
    cmp8(dac_steps, 8'h41);
    $display("test 1 done");
    unl <= 1'b1;
    i2w(8'h9e, {7'h15, 1'b1}, a1, a2);
    cmp1(a1 & a2, 1'b1);
    cmp8({1'b0, dac_code}, 8'h15);
    wb(1'b0, REG_STAT, 32'h0, rd);
    cmp8({rd[7], rd[14:8]}, 8'h40);
    $display("test 2 done");
    unl <= 1'b0;
    m_u.start();
    m_u.wbyte(8'h9e, a1);
    m_u.wbyte({7'h11, 1'b1}, a2);
    m_u.wbyte({7'h22, 1'b0}, b);
    m_u.stop();
    cmp1(a1 & a2 & b, 1'b1);
    cmp8({ee_busy, dac_code}, 8'h22);
    cmp8(dac_steps, 8'h23);
    wb(1'b0, REG_STAT, 32'h0, rd);
    cmp8({1'b0, rd[14:8]}, 8'h40);
    $display("test 3 done");
    unl <= 1'b1;
    i2w(8'h9e, {7'h7f, 1'b0}, a1, a2);
    cmp1(ee_busy, 1'b1);
    i2r(a1, d);
    cmp8(d, {7'h7f, 1'b0});
    wb(1'b0, REG_STAT, 32'h0, rd);
    // the stored copy only changes once programming is over
    cmp8({rd[7], rd[14:8]}, {1'b1, 7'h40});
    while (ee_busy !== 1'b0) @(posedge mclk);
    wb(1'b0, REG_STAT, 32'h0, rd);
    cmp8({rd[15], rd[14:8]}, {1'b1, 7'h7f});
    i2r(a1, d);
    cmp8(d, {7'h7f, 1'b1});
    cmp8(dac_steps, 8'h80);
    $display("test 4 done");
    m_u.start();
    m_u.wbyte(8'h9c, a1);
    cmp1(a1, 1'b0);
    m_u.start();
    m_u.wbyte(8'h9e, a1);
    m_u.wbyte({7'h05, 1'b1}, a2);
    m_u.stop();
    cmp1(a1 & a2, 1'b1);
    cmp8({1'b0, dac_code}, 8'h05);
    $display("test 5 done");
    wb(1'b1, REG_CTRL, 32'h0, rd);
    i2w(8'h9e, {7'h33, 1'b1}, a1, a2);
    cmp1(a1, 1'b0);
    wb(1'b1, REG_CTRL, 32'h1, rd);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    cmp8(rd[7:0], 8'h01);
    wb(1'b1, REG_STAT, 32'h0, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    cmp8(rd[7:0] | rd[15:8], 8'h00);
    cmp8({1'b0, dac_code}, 8'h05);
    $display("test 6 done");
    results();
  end
endmodule
